// >>> verilog/uart_decode_trigger.sv
// passive uart line decoder with trigger engine and avalon register slave
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module uart_decode_trigger
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic line_in,
	input wire logic [5:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	output logic trigger_out,
	output logic [8:0] symbol_out,
	output logic symbol_valid_out
);
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_HOLD, ST_BREAK}
		rx_state_t;

	// mask of the active symbol bits
	function automatic logic [8:0] width_mask(input logic [3:0] bits);
		return 9'h1ff >> (4'h9 - bits);
	endfunction

	// masked compare; hex entry turns the care mask into one whole-symbol flag
	function automatic logic sym_match(input logic [8:0] sym, input logic [8:0] val,
		input logic [8:0] care, input logic ign, input logic hex, input logic [8:0] wmask);
		logic [8:0] eff;
		eff = hex ? {9{~ign}} : care;
		return (((sym ^ val) & eff & wmask) == 9'h000);
	endfunction

	// byte lane merge for partial writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[8*i +: 8] = wd[8*i +: 8];
		end
		return res;
	endfunction

	// address decode of compare word i, shared by the read image and the write path
	function automatic logic is_cmp_addr(input logic [5:0] addr, input int i);
		return addr == uart_trig_pkg::OFF_CMP0 + 6'(uart_trig_pkg::CMP_STRIDE * 6'(i));
	endfunction

	logic rst_s1; // reset release stage one
	logic rst_n; // released reset used everywhere else
	logic line_s1; // first synchroniser stage, read only by line_s2
	logic line_s2; // synchronised line level

	// configuration registers
	logic pol_low, next_pol_low;
	logic [3:0] sym_bits, next_sym_bits;
	logic [1:0] par_mode, next_par_mode;
	logic [1:0] stop_mode, next_stop_mode;
	logic [2:0] trig_mode, next_trig_mode;
	logic [1:0] pattern_length, next_pattern_length;
	logic hex_mode, next_hex_mode;
	logic [15:0] bit_period, next_bit_period; // clock cycles per bit
	logic [23:0] idle_time, next_idle_time; // clock cycles of quiet line
	logic [23:0] break_time, next_break_time; // clock cycles of low line
	logic [11:0] sym_index, next_sym_index;
	logic [11:0] skip_count, next_skip_count;
	logic [8:0] cmp_val [0:2];
	logic [8:0] next_cmp_val [0:2];
	logic [8:0] cmp_care [0:2];
	logic [8:0] next_cmp_care [0:2];
	logic cmp_ign [0:2];
	logic next_cmp_ign [0:2];
	logic [31:0] next_readdata;
	logic next_wait;
	logic [31:0] cur_word; // image of the addressed register
	logic [31:0] merged; // write data merged into that image
	logic wr_go; // write takes effect this edge

	// receiver state
	rx_state_t state, next_state;
	logic [16:0] timer, next_timer; // cycles inside the current bit
	logic [3:0] bit_idx, next_bit_idx;
	logic [8:0] shreg, next_shreg; // data bits, lsb first
	logic [23:0] gap_cnt, next_gap_cnt; // quiet time since last stop
	logic [23:0] brk_cnt, next_brk_cnt; // low time since start edge
	logic frame_open, next_frame_open;
	logic [12:0] sym_cnt, next_sym_cnt; // symbols done in this frame
	logic [8:0] hist0, next_hist0; // previous symbol
	logic [8:0] hist1, next_hist1; // symbol before that
	logic next_trigger;
	logic [8:0] next_symbol;
	logic next_symbol_valid;
	logic [15:0] trig_count, next_trig_count;

	// decoded events and helpers
	logic rx_bit; // line level as logic value
	logic [8:0] wmask;
	logic [16:0] half;
	logic [16:0] per_m1;
	logic [16:0] remain;
	logic [12:0] pat_pos;
	logic pat_hit;
	logic start_ev, fstart_ev, sym_ev, par_ev, ferr_ev, brk_ev;

	// reset release: async assert, sync release
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// the observed line is asynchronous to our clock
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// idle mark level, so no false start edge follows reset
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
		end
		else
		begin
			line_s1 <= line_in;
			line_s2 <= line_s1;
		end
	end

	assign rx_bit = line_s2 ^ pol_low;
	assign wmask = width_mask(sym_bits);
	assign half = {2'h0, bit_period[15:1]};
	assign per_m1 = {1'b0, bit_period - 16'h0001};
	assign pat_pos = {1'b0, skip_count} + {11'h000, pattern_length} - 13'h0001;
	assign wr_go = write_in && !waitrequest_out;

	// pattern match on the symbol now completing, older ones from history
	always_comb
	begin
		unique case (pattern_length)
			2'h2: pat_hit = sym_match(hist0, cmp_val[0], cmp_care[0], cmp_ign[0], hex_mode, wmask)
				&& sym_match(shreg, cmp_val[1], cmp_care[1], cmp_ign[1], hex_mode, wmask);
			2'h3: pat_hit = sym_match(hist1, cmp_val[0], cmp_care[0], cmp_ign[0], hex_mode, wmask)
				&& sym_match(hist0, cmp_val[1], cmp_care[1], cmp_ign[1], hex_mode, wmask)
				&& sym_match(shreg, cmp_val[2], cmp_care[2], cmp_ign[2], hex_mode, wmask);
			default: pat_hit = sym_match(shreg, cmp_val[0], cmp_care[0], cmp_ign[0], hex_mode, wmask);
		endcase
		pat_hit = pat_hit && (sym_cnt == pat_pos);
	end

	// remaining stop time after the mid-bit stop sample
	always_comb
	begin
		unique case (stop_mode)
			uart_trig_pkg::STOP_ONE_HALF: remain = {1'b0, bit_period};
			uart_trig_pkg::STOP_TWO: remain = {1'b0, bit_period} + half;
			default: remain = half;
		endcase
	end

	// receiver next state, events and trigger selection
	always_comb
	begin
		next_state = state;
		next_timer = timer + 17'h00001;
		next_bit_idx = bit_idx;
		next_shreg = shreg;
		next_gap_cnt = 24'h000000;
		next_frame_open = frame_open;
		next_sym_cnt = sym_cnt;
		next_hist0 = hist0;
		next_hist1 = hist1;
		next_symbol = symbol_out;
		next_symbol_valid = 1'b0;
		start_ev = 1'b0;
		fstart_ev = 1'b0;
		sym_ev = 1'b0;
		par_ev = 1'b0;
		ferr_ev = 1'b0;
		brk_ev = 1'b0;
		unique case (state)
			ST_IDLE:
			begin
				next_timer = 17'h00000;
				next_gap_cnt = gap_cnt;
				if (!rx_bit)
				begin
					// a quiet gap long enough opens a new frame; inside an
					// open frame the next start follows the stop directly
					if (gap_cnt >= idle_time)
					begin
						fstart_ev = 1'b1;
						start_ev = 1'b1;
					end
					else if (frame_open)
						start_ev = 1'b1;
					next_gap_cnt = 24'h000000;
				end
				else if (gap_cnt != 24'hffffff)
					next_gap_cnt = gap_cnt + 24'h000001;
				if (rx_bit && gap_cnt >= idle_time)
					next_frame_open = 1'b0; // frame closes once the line is quiet
				if (start_ev)
				begin
					next_state = ST_START;
					next_frame_open = 1'b1;
					next_shreg = 9'h000;
					next_bit_idx = 4'h0;
					if (fstart_ev)
						next_sym_cnt = 13'h0000;
				end
			end
			ST_START:
			begin
				// confirm at mid bit; a short glitch drops back to idle
				if (timer == half)
				begin
					next_timer = 17'h00000;
					next_state = rx_bit ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (timer == per_m1)
				begin
					next_timer = 17'h00000;
					next_shreg[bit_idx] = rx_bit;
					next_bit_idx = bit_idx + 4'h1;
					if (bit_idx == sym_bits - 4'h1)
						next_state = (par_mode == uart_trig_pkg::PAR_EVEN
							|| par_mode == uart_trig_pkg::PAR_ODD) ? ST_PARITY : ST_STOP;
				end
			end
			ST_PARITY:
			begin
				if (timer == per_m1)
				begin
					next_timer = 17'h00000;
					next_state = ST_STOP;
					if (par_mode == uart_trig_pkg::PAR_EVEN)
						par_ev = (rx_bit != (^shreg));
					else
						par_ev = (rx_bit != (~^shreg));
				end
			end
			ST_STOP:
			begin
				if (timer == per_m1)
				begin
					next_timer = 17'h00000;
					if (rx_bit)
					begin
						sym_ev = 1'b1;
						next_state = ST_HOLD;
						next_hist0 = shreg;
						next_hist1 = hist0;
						next_symbol = shreg;
						next_symbol_valid = 1'b1;
						if (sym_cnt != 13'h1fff)
							next_sym_cnt = sym_cnt + 13'h0001;
					end
					else
					begin
						ferr_ev = 1'b1;
						next_state = ST_IDLE;
						next_frame_open = 1'b0;
					end
				end
			end
			ST_HOLD:
			begin
				// a low level before the stop time is over is a bad stop; the stop
				// sample sits one cycle past mid bit, so idle is entered a little
				// early to catch a start that follows the stop at once
				if (!rx_bit)
				begin
					ferr_ev = 1'b1;
					next_state = ST_IDLE;
					next_frame_open = 1'b0;
				end
				else if (timer + 17'h00003 >= remain)
					next_state = ST_IDLE;
			end
			ST_BREAK:
			begin
				// wait for the line to return before looking for starts
				next_timer = 17'h00000;
				if (rx_bit)
					next_state = ST_IDLE;
			end
		endcase
		// break counting runs from the start edge while the line stays low
		next_brk_cnt = 24'h000000;
		if (!rx_bit && state != ST_BREAK && (state != ST_IDLE || brk_cnt != 24'h000000
			|| start_ev))
			next_brk_cnt = brk_cnt + 24'h000001;
		if (!rx_bit && state != ST_BREAK && brk_cnt != 24'h000000
			&& {1'b0, brk_cnt} + 25'h0000001 >= {1'b0, break_time})
		begin
			brk_ev = 1'b1;
			next_state = ST_BREAK;
			next_frame_open = 1'b0;
			next_brk_cnt = 24'h000000;
		end
		// trigger selection, one pulse per event
		unique case (trig_mode)
			uart_trig_pkg::MODE_START: next_trigger = start_ev;
			uart_trig_pkg::MODE_FRAME: next_trigger = fstart_ev;
			uart_trig_pkg::MODE_INDEX:
				next_trigger = sym_ev && (sym_cnt == {1'b0, sym_index});
			uart_trig_pkg::MODE_ANY:
				next_trigger = sym_ev && sym_match(shreg, cmp_val[0], cmp_care[0],
					cmp_ign[0], hex_mode, wmask);
			uart_trig_pkg::MODE_PATTERN: next_trigger = sym_ev && pat_hit;
			uart_trig_pkg::MODE_PARITY: next_trigger = par_ev;
			uart_trig_pkg::MODE_FRAME_ERR: next_trigger = ferr_ev;
			uart_trig_pkg::MODE_BREAK: next_trigger = brk_ev;
		endcase
		next_trig_count = trig_count + {15'h0000, next_trigger};
	end

	// receiver registers
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			timer <= 17'h00000;
			bit_idx <= 4'h0;
			shreg <= 9'h000;
			gap_cnt <= 24'h000000;
			brk_cnt <= 24'h000000;
			frame_open <= 1'b0;
			sym_cnt <= 13'h0000;
			hist0 <= 9'h000;
			hist1 <= 9'h000;
			trigger_out <= 1'b0;
			symbol_out <= 9'h000;
			symbol_valid_out <= 1'b0;
			trig_count <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			timer <= next_timer;
			bit_idx <= next_bit_idx;
			shreg <= next_shreg;
			gap_cnt <= next_gap_cnt;
			brk_cnt <= next_brk_cnt;
			frame_open <= next_frame_open;
			sym_cnt <= next_sym_cnt;
			hist0 <= next_hist0;
			hist1 <= next_hist1;
			trigger_out <= next_trigger;
			symbol_out <= next_symbol;
			symbol_valid_out <= next_symbol_valid;
			trig_count <= next_trig_count;
		end
	end

	// register image of the addressed word; unmapped reads as zero
	always_comb
	begin
		cur_word = 32'h00000000;
		case (address_in)
			uart_trig_pkg::OFF_CTRL: cur_word = {17'h00000, hex_mode, pattern_length, trig_mode,
				stop_mode, par_mode, sym_bits, pol_low};
			uart_trig_pkg::OFF_PERIOD: cur_word = {16'h0000, bit_period};
			uart_trig_pkg::OFF_IDLE: cur_word = {8'h00, idle_time};
			uart_trig_pkg::OFF_BREAK: cur_word = {8'h00, break_time};
			uart_trig_pkg::OFF_INDEX: cur_word = {20'h00000, sym_index};
			uart_trig_pkg::OFF_SKIP: cur_word = {20'h00000, skip_count};
			uart_trig_pkg::OFF_STATUS:
				cur_word = {17'h00000, sym_cnt, frame_open, state != ST_IDLE};
			uart_trig_pkg::OFF_LAST: cur_word = {trig_count, 7'h00, symbol_out};
			default: cur_word = 32'h00000000;
		endcase
		for (int i = 0; i < 3; i++)
		begin
			if (is_cmp_addr(address_in, i))
				cur_word = {cmp_ign[i], 6'h00, cmp_care[i], 7'h00, cmp_val[i]};
		end
		merged = lane_merge(cur_word, writedata_in, byteenable_in);
	end

	// bus next values: one wait cycle, then the access completes
	always_comb
	begin
		next_wait = !((read_in || write_in) && waitrequest_out);
		next_readdata = (read_in && waitrequest_out) ? cur_word : readdata_out;
		next_pol_low = pol_low;
		next_sym_bits = sym_bits;
		next_par_mode = par_mode;
		next_stop_mode = stop_mode;
		next_trig_mode = trig_mode;
		next_pattern_length = pattern_length;
		next_hex_mode = hex_mode;
		next_bit_period = bit_period;
		next_idle_time = idle_time;
		next_break_time = break_time;
		next_sym_index = sym_index;
		next_skip_count = skip_count;
		for (int i = 0; i < 3; i++)
		begin
			next_cmp_val[i] = cmp_val[i];
			next_cmp_care[i] = cmp_care[i];
			next_cmp_ign[i] = cmp_ign[i];
			if (wr_go && is_cmp_addr(address_in, i))
			begin
				next_cmp_val[i] = merged[8:0];
				next_cmp_care[i] = merged[uart_trig_pkg::CMP_CARE +: 9];
				next_cmp_ign[i] = merged[uart_trig_pkg::CMP_IGN];
			end
		end
		if (wr_go)
		begin
			case (address_in)
				uart_trig_pkg::OFF_CTRL:
				begin
					next_pol_low = merged[uart_trig_pkg::CTRL_POL];
					// out of range widths and lengths keep the old setting
					if (merged[uart_trig_pkg::CTRL_BITS +: 4] >= uart_trig_pkg::SYM_MIN
						&& merged[uart_trig_pkg::CTRL_BITS +: 4] <= uart_trig_pkg::SYM_MAX)
						next_sym_bits = merged[uart_trig_pkg::CTRL_BITS +: 4];
					next_par_mode = merged[uart_trig_pkg::CTRL_PAR +: 2];
					next_stop_mode = merged[uart_trig_pkg::CTRL_STOP +: 2];
					next_trig_mode = merged[uart_trig_pkg::CTRL_MODE +: 3];
					if (merged[uart_trig_pkg::CTRL_LEN +: 2] != 2'h0)
						next_pattern_length = merged[uart_trig_pkg::CTRL_LEN +: 2];
					next_hex_mode = merged[uart_trig_pkg::CTRL_HEX];
				end
				uart_trig_pkg::OFF_PERIOD: next_bit_period = merged[15:0];
				uart_trig_pkg::OFF_IDLE: next_idle_time = merged[23:0];
				uart_trig_pkg::OFF_BREAK: next_break_time = merged[23:0];
				uart_trig_pkg::OFF_INDEX: next_sym_index = merged[11:0];
				uart_trig_pkg::OFF_SKIP: next_skip_count = merged[11:0];
				default: next_sym_index = sym_index;
			endcase
		end
	end

	// bus and configuration registers
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			waitrequest_out <= 1'b1;
			readdata_out <= 32'h00000000;
			pol_low <= 1'b0;
			sym_bits <= uart_trig_pkg::RST_BITS;
			par_mode <= uart_trig_pkg::PAR_NONE;
			stop_mode <= uart_trig_pkg::STOP_ONE;
			trig_mode <= uart_trig_pkg::MODE_START;
			pattern_length <= uart_trig_pkg::RST_LEN;
			hex_mode <= 1'b0;
			bit_period <= uart_trig_pkg::RST_PERIOD;
			idle_time <= uart_trig_pkg::RST_IDLE;
			break_time <= uart_trig_pkg::RST_BREAK;
			sym_index <= 12'h000;
			skip_count <= 12'h000;
			for (int i = 0; i < 3; i++)
			begin
				cmp_val[i] <= 9'h000;
				cmp_care[i] <= 9'h000;
				cmp_ign[i] <= 1'b0;
			end
		end
		else
		begin
			waitrequest_out <= next_wait;
			readdata_out <= next_readdata;
			pol_low <= next_pol_low;
			sym_bits <= next_sym_bits;
			par_mode <= next_par_mode;
			stop_mode <= next_stop_mode;
			trig_mode <= next_trig_mode;
			pattern_length <= next_pattern_length;
			hex_mode <= next_hex_mode;
			bit_period <= next_bit_period;
			idle_time <= next_idle_time;
			break_time <= next_break_time;
			sym_index <= next_sym_index;
			skip_count <= next_skip_count;
			for (int i = 0; i < 3; i++)
			begin
				cmp_val[i] <= next_cmp_val[i];
				cmp_care[i] <= next_cmp_care[i];
				cmp_ign[i] <= next_cmp_ign[i];
			end
		end
	end

	// checks on the receiver and trigger path
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n);

	trig_pulse_a: assert property (trigger_out |=> !trigger_out)
		else $error("trigger longer than one cycle");
	start_level_a: assert property (start_ev |-> (line_s2 == pol_low))
		else $error("start taken on a logic one level");
	idle_gate_a: assert property ((start_ev && !frame_open) |-> (gap_cnt >= idle_time))
		else $error("start accepted inside idle time");
	frame_first_a: assert property (fstart_ev |=> (frame_open && sym_cnt == 13'h0000))
		else $error("frame start did not open a fresh frame");
	start_trig_a: assert property ((trig_mode == uart_trig_pkg::MODE_START && start_ev)
		|=> trigger_out)
		else $error("start trigger missing");
	mid_sample_a: assert property ((state == ST_START && timer == half && !rx_bit)
		|=> (state == ST_DATA && timer == 17'h00000))
		else $error("start not confirmed at mid bit");
	sym_width_a: assert property (symbol_valid_out |-> ((symbol_out & ~wmask) == 9'h000))
		else $error("symbol wider than configured");
	parity_err_a: assert property (par_ev
		|-> (par_mode != uart_trig_pkg::PAR_NONE) ##1 (state == ST_STOP))
		else $error("parity error outside parity slot");
	frame_err_a: assert property (ferr_ev
		|-> !rx_bit ##1 (!frame_open && state != ST_HOLD))
		else $error("frame error without low stop level");
	break_a: assert property (brk_ev |-> !rx_bit ##1 (state == ST_BREAK))
		else $error("break not entered");
	index_trig_a: assert property ((trig_mode == uart_trig_pkg::MODE_INDEX
		&& sym_ev && sym_cnt == {1'b0, sym_index}) |=> (trigger_out && symbol_valid_out))
		else $error("index trigger missing");
endmodule

// >>> common/uart_trig_pkg.sv
// constants for the uart decode and trigger block
// Operation
// - polarity selects which line level means one
// - symbol width five to nine data bits
// - even parity: one when ones count odd
// - odd parity: one when ones count even
// - stop length one, one half, two bits
// - bit period follows programmed bit rate
// - start after idle gap begins new frame
// - start inside running idle gap ignored
// - start trigger on first zero after stop
// - frame start only on first frame start
// - index trigger on Nth symbol of frame
// - any symbol compared against stored value
// - compare bits one, zero or ignored
// - hex entry ignores whole symbol at once
// - pattern skips 0 to 4095 leading symbols
// - pattern of one, two or three symbols
// - pattern compare uses configured symbol width
// - parity error trigger on parity mismatch
// - frame error trigger on bad stop level
// - break trigger when line stays low long
package uart_trig_pkg;
	// register byte offsets, one aligned word each
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_PERIOD = 6'h04;
	localparam logic [5:0] OFF_IDLE = 6'h08;
	localparam logic [5:0] OFF_BREAK = 6'h0c;
	localparam logic [5:0] OFF_INDEX = 6'h10;
	localparam logic [5:0] OFF_SKIP = 6'h14;
	localparam logic [5:0] OFF_CMP0 = 6'h18;
	localparam logic [5:0] CMP_STRIDE = 6'h04;
	localparam logic [5:0] OFF_STATUS = 6'h24;
	localparam logic [5:0] OFF_LAST = 6'h28;
	// control word field positions
	localparam int CTRL_POL = 0;
	localparam int CTRL_BITS = 1;
	localparam int CTRL_PAR = 5;
	localparam int CTRL_STOP = 7;
	localparam int CTRL_MODE = 9;
	localparam int CTRL_LEN = 12;
	localparam int CTRL_HEX = 14;
	// compare word field positions
	localparam int CMP_CARE = 16;
	localparam int CMP_IGN = 31;
	// symbol width limits
	localparam logic [3:0] SYM_MIN = 4'h5;
	localparam logic [3:0] SYM_MAX = 4'h9;
	// parity, stop and trigger mode codes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] STOP_ONE = 2'h0;
	localparam logic [1:0] STOP_ONE_HALF = 2'h1;
	localparam logic [1:0] STOP_TWO = 2'h2;
	localparam logic [2:0] MODE_START = 3'h0;
	localparam logic [2:0] MODE_FRAME = 3'h1;
	localparam logic [2:0] MODE_INDEX = 3'h2;
	localparam logic [2:0] MODE_ANY = 3'h3;
	localparam logic [2:0] MODE_PATTERN = 3'h4;
	localparam logic [2:0] MODE_PARITY = 3'h5;
	localparam logic [2:0] MODE_FRAME_ERR = 3'h6;
	localparam logic [2:0] MODE_BREAK = 3'h7;
	// reset values
	localparam logic [3:0] RST_BITS = 4'h8;
	localparam logic [1:0] RST_LEN = 2'h1;
	localparam logic [15:0] RST_PERIOD = 16'h06c8;
	localparam logic [23:0] RST_IDLE = 24'h000400;
	localparam logic [23:0] RST_BREAK = 24'h010000;
endpackage

// >>> verif/uart_tx_model.sv
// behavioural transmitter driving the observed serial line
`timescale 1ns/1ps
module uart_tx_model
(
	input wire logic clk_in,
	output logic line_out
);
	int period = 16; // cycles per bit, same as the programmed period
	int nb = 8; // data bits per symbol
	int par = 0; // 0 none, 1 even, 2 odd
	int stop = 0; // 0 one, 1 one and a half, 2 two bit times
	logic pol = 1'b0; // set when a low line means logic one
	// idle at mark so no false start is seen out of reset
	initial
		line_out = 1'b1;
	// hold one logic level for n cycles, launched just after an edge
	task level(input logic v, input int n);
		line_out <= v ^ pol;
		repeat (n) @(posedge clk_in);
	endtask
	// one whole symbol; faults only when the bench asks for them
	task send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
		level(1'b0, period);
		for (int i = 0; i < nb; i++)
			level(d[i], period);
		if (par != 0)
			level(1'(($countones(d) + par + 1) % 2) ^ bad_par, period);
		level(~bad_stop, period * (2 + stop) / 2);
	endtask
endmodule

// >>> verif/uart_decode_trigger_test.sv
// self-checking bench for the uart decode and trigger block
`timescale 1ns/1ps
module uart_decode_trigger_test;
	logic clk_in = 1'b0; // 200 MHz sampling clock
	logic rst_n_in = 1'b0;
	wire line_in; // driven by the transmitter model
	logic [5:0] address_in = 6'h00;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0;
	logic [3:0] byteenable_in = 4'hf; // whole words only
	logic [31:0] readdata_out;
	logic waitrequest_out;
	logic trigger_out;
	logic [8:0] symbol_out;
	logic symbol_valid_out;
	int mismatches = 0;
	int comparisons = 0;
	int trig = 0; // trigger pulses seen
	int n;
	logic [8:0] got_q[$]; // symbols the block reported
	logic [8:0] sym[3]; // symbols of the current frame
	logic [8:0] care;
	logic [31:0] rd; // last read data
	always #2.5 clk_in = ~clk_in;
	uart_tx_model tx (.clk_in(clk_in), .line_out(line_in));
	uart_decode_trigger dut
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.line_in(line_in),
		.address_in(address_in),
		.read_in(read_in),
		.write_in(write_in),
		.writedata_in(writedata_in),
		.byteenable_in(byteenable_in),
		.readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out),
		.trigger_out(trigger_out),
		.symbol_out(symbol_out),
		.symbol_valid_out(symbol_valid_out)
	);
	// monitor: at the edge the outputs still show the settled cycle
	always @(posedge clk_in)
	begin
		if (trigger_out === 1'b1)
			trig <= trig + 1;
		if (symbol_valid_out === 1'b1)
			got_q.push_back(symbol_out);
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access: held until waitrequest is sampled low at a rising edge,
	// read data taken at that edge; only the watchdog ends a stuck wait
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		address_in <= a;
		writedata_in <= d;
		write_in <= wr;
		read_in <= ~wr;
		@(posedge clk_in);
		while (waitrequest_out !== 1'b0)
			@(posedge clk_in);
		rd = readdata_out;
		write_in <= 1'b0;
		read_in <= 1'b0;
	endtask
	function automatic logic [31:0] ctrl(input int p, b, pr, s, m, l, h);
		return 32'(p | b << 1 | pr << 5 | s << 7 | m << 9 | l << 12 | h << 14);
	endfunction
	// program format and mode, settle the line, pick fresh symbols
	task setup(input int p, b, pr, s, m, l = 1, h = 0);
		bus(1'b1, uart_trig_pkg::OFF_CTRL, ctrl(p, b, pr, s, m, l, h));
		tx.pol = 1'(p);
		tx.nb = b;
		tx.par = pr;
		tx.stop = s;
		tx.level(1'b1, 200);
		got_q.delete();
		trig = 0;
		for (int i = 0; i < 3; i++)
			sym[i] = 9'($urandom) & 9'((1 << b) - 1);
	endtask
	// send k symbols back to back, then a gap longer than the idle time
	task frame(input int k, input logic bp = 1'b0, input logic bs = 1'b0);
		for (int i = 0; i < k; i++)
			tx.send(sym[i], bp, bs);
		tx.level(1'b1, 150);
	endtask
	task verify(input string name, input int nt, input int ns);
		check(trig, nt);
		check(got_q.size(), ns);
		for (int i = 0; i < got_q.size(); i++)
			check(got_q[i], sym[i % 3]);
		$display("test %s done", name);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog sized well above the longest expected run
	initial
	begin
		repeat (99000) @(posedge clk_in);
		mismatches++;
		complete_run;
	end
	initial
	begin
		void'($urandom(55894));
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		bus(1'b0, uart_trig_pkg::OFF_CTRL, 32'h0);
		check(rd, 32'h1010);
		bus(1'b0, uart_trig_pkg::OFF_PERIOD, 32'h0);
		check(rd, {16'h0, uart_trig_pkg::RST_PERIOD});
		bus(1'b0, 6'h3c, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, uart_trig_pkg::OFF_PERIOD, 32'h10);
		bus(1'b1, uart_trig_pkg::OFF_IDLE, 32'h40);
		bus(1'b1, uart_trig_pkg::OFF_BREAK, 32'h190);
		bus(1'b1, uart_trig_pkg::OFF_CTRL, 32'h8);
		bus(1'b0, uart_trig_pkg::OFF_CTRL, 32'h0);
		check(rd, 32'h1010);
		$display("test registers done");
		// every width, parity and stop length, random polarity and mask
		for (int b = 5; b <= 9; b++)
			for (int pr = 0; pr < 3; pr++)
				for (int s = 0; s < 3; s++)
				begin
					setup($urandom % 2, b, pr, s, 3);
					care = 9'($urandom);
					bus(1'b1, uart_trig_pkg::OFF_CMP0, {7'h0, care, 7'h0, sym[1]});
					frame(3);
					n = 0;
					for (int i = 0; i < 3; i++)
						n += int'(((sym[i] ^ sym[1]) & care) == 9'h0);
					verify("any", n, 3);
				end
		setup(0, 8, 1, 0, 5);
		frame(1, 1'b1);
		verify("parity", 1, 1);
		setup(0, 7, 2, 1, 5);
		frame(2);
		verify("parity_ok", 0, 2);
		setup(0, 8, 0, 2, 6);
		frame(1, 1'b0, 1'b1);
		verify("frame_err", 1, 0);
		setup(0, 8, 0, 0, 7);
		tx.level(1'b0, 500);
		tx.level(1'b1, 150);
		verify("break", 1, 0);
		setup(0, 8, 0, 0, 0);
		frame(3);
		verify("start", 3, 3);
		setup(0, 8, 0, 0, 1);
		frame(3);
		frame(2);
		verify("frame_start", 2, 5);
		setup(1, 6, 0, 0, 2);
		bus(1'b1, uart_trig_pkg::OFF_INDEX, 32'h2);
		frame(3);
		verify("index", 1, 3);
		setup(0, 5, 1, 2, 4, 3);
		for (int i = 0; i < 3; i++)
			bus(1'b1, 6'(uart_trig_pkg::OFF_CMP0 + 4 * i), {7'h0, 9'h1ff, 7'h0, sym[i]});
		frame(3);
		verify("pattern", 1, 3);
		setup(0, 9, 0, 0, 4, 2, 1);
		bus(1'b1, uart_trig_pkg::OFF_SKIP, 32'h1);
		bus(1'b1, uart_trig_pkg::OFF_CMP0, {23'h0, sym[1]});
		bus(1'b1, 6'h1c, {23'h400000, ~sym[2]});
		frame(3);
		verify("pattern_hex", 1, 3);
		complete_run;
	end
endmodule
